/* File: core/bsg_defines.vh */
// Offsets, field layout, reset values and codes for the bit sync config block
`ifndef BSG_DEFINES_VH
`define BSG_DEFINES_VH

// Register offsets
`define BSG_ADDR_BIT_SYNC_CONFIG     8'h1a
`define BSG_ADDR_GAIN_CTRL_LIMITS    8'h1b
`define BSG_ADDR_LOOP_STATUS         8'h3a

// bit_sync_config fields
`define BSG_PRE_KI_MSB               7
`define BSG_PRE_KI_LSB               6
`define BSG_PRE_KP_MSB               5
`define BSG_PRE_KP_LSB               4
`define BSG_POST_KI_BIT              3
`define BSG_POST_KP_BIT              2
`define BSG_RATE_SAT_MSB             1
`define BSG_RATE_SAT_LSB             0
`define BSG_BIT_SYNC_CONFIG_RST      8'h6c

// gain_control_limits fields
`define BSG_DIGITAL_VARIABLE_GAIN_AMP_CAP_MSB             7
`define BSG_DIGITAL_VARIABLE_GAIN_AMP_CAP_LSB             6
`define BSG_FRONT_CAP_MSB            5
`define BSG_FRONT_CAP_LSB            3
`define BSG_AMP_TARGET_MSB           2
`define BSG_AMP_TARGET_LSB           0
`define BSG_GAIN_CTRL_LIMITS_RST     8'h03

// loop_status fields
`define BSG_STAT_POST_SYNC_BIT       0
`define BSG_STAT_RATE_EN_BIT         1
`define BSG_STAT_KI_MSB              7
`define BSG_STAT_KI_LSB              4

// Loop gains in half-base units
`define BSG_GAIN_HALF_ONE            4'h2
`define BSG_GAIN_HALF_HALF           4'h1
`define BSG_KI_RST_HALF              4'h4
`define BSG_KP_RST_HALF              4'h6

// Rate offset limit in units of 1/32 of the data rate
`define BSG_RATE_LIM_OFF             3'h0
`define BSG_RATE_LIM_3P125           3'h1
`define BSG_RATE_LIM_6P25            3'h2
`define BSG_RATE_LIM_12P5            3'h4

// Amplitude target in dB, reset code 3
`define BSG_TARGET_RST_DB            6'h21

`endif

/* File: core/bsg_loop_gain_sel.v */
// Clock recovery loop gain selector for one gain path
`timescale 1ns/1ns
`default_nettype none
`include "bsg_defines.vh"

module bsg_loop_gain_sel #(
    parameter [3:0] POST_SET_HALF = 4'h2
) (
    input  wire [1:0] pre_code,
    input  wire       post_sel,
    input  wire       post_sync,
    output reg  [3:0] gain_half
);

    // Pre-sync gain: (code + 1) times base, in half units
    function [3:0] pre_gain_half;
        input [1:0] code;
        begin
            pre_gain_half = {1'b0, code, 1'b0} + `BSG_GAIN_HALF_ONE;
        end
    endfunction

    always @* begin
        if (post_sync && post_sel) begin
            gain_half = POST_SET_HALF;
        end else begin
            gain_half = pre_gain_half(pre_code);
        end
    end

endmodule // bsg_loop_gain_sel

`default_nettype wire

/* File: core/bsg_bitsync_agc_cfg.v */
// Bit synchronisation and gain limit configuration registers
// Summary of operation
// - Post-sync integral gain bit 3 (reset 1): 0 keeps pre-sync, 1 half base.
// - Post-sync proportional gain bit 2 (reset 1): 0 keeps pre-sync, 1 base.
// - Rate offset clamp bits 1:0 (reset 0): off, 3.125, 6.25, 12.5 percent.
// - Digital gain cap bits 7:6 (reset 0) removes the top 0 to 3 settings.
// - Front amp cap bits 5:3 (reset 0) caps gain 0 to 17.1 dB below max.
// - Amplitude target bits 2:0 (reset 3) selects 24 up to 42 dB.
// - Pre-sync integral gain bits 7:6 (reset 1) gives one to four times base.
// - Pre-sync proportional gain bits 5:4 (reset 2) gives one to four times.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "bsg_defines.vh"

module bsg_bitsync_agc_cfg #(
    parameter       DIGITAL_VARIABLE_GAIN_AMP_W   = 3,
    parameter [2:0] DIGITAL_VARIABLE_GAIN_AMP_TOP = 3'h7
) (
    input  wire              mclk,
    input  wire              arst_n,
    input  wire [7:0]        reg_addr,
    input  wire [7:0]        reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [7:0]        reg_rdata,
    input  wire              sync_detected,
    input  wire              rx_restart,
    input  wire [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] digital_variable_gain_amp_gain_req,
    input  wire [2:0]        front_amp_step_req,
    output reg               loop_post_sync,
    output reg  [3:0]        integral_gain_half,
    output reg  [3:0]        proportional_gain_half,
    output reg               rate_correction_en,
    output reg  [2:0]        rate_offset_limit,
    output reg  [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] digital_vga_gain,
    output reg  [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] digital_vga_top,
    output reg  [2:0]        front_amp_step,
    output reg  [7:0]        front_amp_cap_db10,
    output reg  [5:0]        amp_target_db
);

    ////////////////////////////////////////////////////////////////////////
    // Decode functions

    // Rate offset limit in 1/32 of the data rate
    function [2:0] rate_limit;
        input [1:0] code;
        begin
            case (code)
                2'h1:    rate_limit = `BSG_RATE_LIM_3P125;
                2'h2:    rate_limit = `BSG_RATE_LIM_6P25;
                2'h3:    rate_limit = `BSG_RATE_LIM_12P5;
                default: rate_limit = `BSG_RATE_LIM_OFF;
            endcase
        end
    endfunction

    // Amplitude target in dB
    function [5:0] target_db;
        input [2:0] code;
        begin
            case (code)
                3'h0:    target_db = 6'h18;
                3'h1:    target_db = 6'h1b;
                3'h2:    target_db = 6'h1e;
                3'h3:    target_db = 6'h21;
                3'h4:    target_db = 6'h24;
                3'h5:    target_db = 6'h26;
                3'h6:    target_db = 6'h28;
                default: target_db = 6'h2a;
            endcase
        end
    endfunction

    // Front amp cap below maximum, tenths of a dB
    function [7:0] front_cap_db10;
        input [2:0] code;
        begin
            case (code)
                3'h1:    front_cap_db10 = 8'h1a;
                3'h2:    front_cap_db10 = 8'h3d;
                3'h3:    front_cap_db10 = 8'h4a;
                3'h4:    front_cap_db10 = 8'h5c;
                3'h5:    front_cap_db10 = 8'h73;
                3'h6:    front_cap_db10 = 8'h92;
                3'h7:    front_cap_db10 = 8'hab;
                default: front_cap_db10 = 8'h00;
            endcase
        end
    endfunction

    // Highest usable digital gain index
    function [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] digital_variable_gain_amp_limit;
        input [1:0] code;
        reg   [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] top;
        begin
            top = DIGITAL_VARIABLE_GAIN_AMP_TOP;
            if (top > {{(DIGITAL_VARIABLE_GAIN_AMP_W-2){1'b0}}, code}) begin
                digital_variable_gain_amp_limit = top - {{(DIGITAL_VARIABLE_GAIN_AMP_W-2){1'b0}}, code};
            end else begin
                digital_variable_gain_amp_limit = {DIGITAL_VARIABLE_GAIN_AMP_W{1'b0}};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file

    reg  [7:0] bit_sync_config;
    reg  [7:0] gain_control_limits;

    wire       hit_bit_sync = (reg_addr == `BSG_ADDR_BIT_SYNC_CONFIG);
    wire       hit_gain_lim = (reg_addr == `BSG_ADDR_GAIN_CTRL_LIMITS);
    wire       hit_status   = (reg_addr == `BSG_ADDR_LOOP_STATUS);

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bit_sync_config     <= `BSG_BIT_SYNC_CONFIG_RST;
            gain_control_limits <= `BSG_GAIN_CTRL_LIMITS_RST;
        end else if (reg_wr) begin
            if (hit_bit_sync) begin
                bit_sync_config <= reg_wdata;
            end
            if (hit_gain_lim) begin
                gain_control_limits <= reg_wdata;
            end
        end
    end

    // Field views
    wire [1:0] pre_sync_integral_gain_sel =
        bit_sync_config[`BSG_PRE_KI_MSB:`BSG_PRE_KI_LSB];
    wire [1:0] pre_sync_proportional_gain_sel =
        bit_sync_config[`BSG_PRE_KP_MSB:`BSG_PRE_KP_LSB];
    wire       post_sync_integral_gain_sel =
        bit_sync_config[`BSG_POST_KI_BIT];
    wire       post_sync_proportional_gain_sel =
        bit_sync_config[`BSG_POST_KP_BIT];
    wire [1:0] rate_offset_saturation =
        bit_sync_config[`BSG_RATE_SAT_MSB:`BSG_RATE_SAT_LSB];
    wire [1:0] digital_vga_gain_cap =
        gain_control_limits[`BSG_DIGITAL_VARIABLE_GAIN_AMP_CAP_MSB:`BSG_DIGITAL_VARIABLE_GAIN_AMP_CAP_LSB];
    wire [2:0] front_amp_gain_cap =
        gain_control_limits[`BSG_FRONT_CAP_MSB:`BSG_FRONT_CAP_LSB];
    wire [2:0] filter_amplitude_target =
        gain_control_limits[`BSG_AMP_TARGET_MSB:`BSG_AMP_TARGET_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Sync state of the clock recovery loop

    localparam [1:0] ST_PRE  = 2'b01;
    localparam [1:0] ST_POST = 2'b10;

    reg  [1:0] loop_state;
    reg  [1:0] next_loop_state;

    // Restart wins over a sync in the same cycle
    always @* begin
        case (loop_state)
            ST_PRE: begin
                if (!rx_restart && sync_detected) begin
                    next_loop_state = ST_POST;
                end else begin
                    next_loop_state = ST_PRE;
                end
            end
            ST_POST: begin
                if (rx_restart) begin
                    next_loop_state = ST_PRE;
                end else begin
                    next_loop_state = ST_POST;
                end
            end
            default: next_loop_state = ST_PRE;
        endcase
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            loop_state <= ST_PRE;
        end else begin
            loop_state <= next_loop_state;
        end
    end

    wire next_post_sync = (next_loop_state == ST_POST);

    ////////////////////////////////////////////////////////////////////////
    // Loop gain selection

    wire [3:0] next_integral_gain_half;
    wire [3:0] next_proportional_gain_half;

    // Integral: pre-sync multiple or half base after sync
    bsg_loop_gain_sel #(
        .POST_SET_HALF (`BSG_GAIN_HALF_HALF)
    ) u_integral_sel (
        .pre_code  (pre_sync_integral_gain_sel),
        .post_sel  (post_sync_integral_gain_sel),
        .post_sync (next_post_sync),
        .gain_half (next_integral_gain_half)
    );

    // Proportional: pre-sync multiple or base after sync
    bsg_loop_gain_sel #(
        .POST_SET_HALF (`BSG_GAIN_HALF_ONE)
    ) u_proportional_sel (
        .pre_code  (pre_sync_proportional_gain_sel),
        .post_sel  (post_sync_proportional_gain_sel),
        .post_sync (next_post_sync),
        .gain_half (next_proportional_gain_half)
    );

    ////////////////////////////////////////////////////////////////////////
    // Gain controller limits

    wire [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] next_digital_variable_gain_amp_top = digital_variable_gain_amp_limit(digital_vga_gain_cap);

    reg  [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] next_digital_variable_gain_amp_gain;
    reg  [2:0]        next_front_step;

    always @* begin
        // Requests above the allowed top are pulled down
        if (digital_variable_gain_amp_gain_req > next_digital_variable_gain_amp_top) begin
            next_digital_variable_gain_amp_gain = next_digital_variable_gain_amp_top;
        end else begin
            next_digital_variable_gain_amp_gain = digital_variable_gain_amp_gain_req;
        end
        // Step 0 is full gain; the cap forces at least its step
        if (front_amp_step_req < front_amp_gain_cap) begin
            next_front_step = front_amp_gain_cap;
        end else begin
            next_front_step = front_amp_step_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs to the datapath

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            loop_post_sync         <= 1'b0;
            integral_gain_half     <= `BSG_KI_RST_HALF;
            proportional_gain_half <= `BSG_KP_RST_HALF;
            rate_correction_en     <= 1'b0;
            rate_offset_limit      <= `BSG_RATE_LIM_OFF;
            digital_vga_gain       <= {DIGITAL_VARIABLE_GAIN_AMP_W{1'b0}};
            digital_vga_top        <= DIGITAL_VARIABLE_GAIN_AMP_TOP;
            front_amp_step         <= 3'h0;
            front_amp_cap_db10     <= 8'h00;
            amp_target_db          <= `BSG_TARGET_RST_DB;
        end else begin
            loop_post_sync         <= next_post_sync;
            integral_gain_half     <= next_integral_gain_half;
            proportional_gain_half <= next_proportional_gain_half;
            rate_correction_en     <= (rate_offset_saturation != 2'h0);
            rate_offset_limit      <=
                rate_limit(rate_offset_saturation);
            digital_vga_gain       <= next_digital_variable_gain_amp_gain;
            digital_vga_top        <= next_digital_variable_gain_amp_top;
            front_amp_step         <= next_front_step;
            front_amp_cap_db10     <=
                front_cap_db10(front_amp_gain_cap);
            amp_target_db          <=
                target_db(filter_amplitude_target);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe

    reg  [7:0] next_rdata;

    always @* begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            if (hit_bit_sync) begin
                next_rdata = bit_sync_config;
            end else if (hit_gain_lim) begin
                next_rdata = gain_control_limits;
            end else if (hit_status) begin
                next_rdata[`BSG_STAT_POST_SYNC_BIT] = loop_post_sync;
                next_rdata[`BSG_STAT_RATE_EN_BIT]   = rate_correction_en;
                next_rdata[`BSG_STAT_KI_MSB:`BSG_STAT_KI_LSB] =
                    integral_gain_half;
            end
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // bsg_bitsync_agc_cfg

`default_nettype wire

/* File: tb/bsg_chk.sv */
// Assertion checker for the bit sync and gain limit configuration block
`timescale 1ns/1ns
`default_nettype none
module bsg_chk #(
    parameter       DIGITAL_VARIABLE_GAIN_AMP_W   = 3,
    parameter [2:0] DIGITAL_VARIABLE_GAIN_AMP_TOP = 3'h7
) (
    input wire logic              mclk,
    input wire logic              arst_n,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              sync_detected,
    input wire logic              rx_restart,
    input wire logic [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] digital_variable_gain_amp_gain_req,
    input wire logic [2:0]        front_amp_step_req,
    input wire logic              loop_post_sync,
    input wire logic [3:0]        integral_gain_half,
    input wire logic [3:0]        proportional_gain_half,
    input wire logic              rate_correction_en,
    input wire logic [2:0]        rate_offset_limit,
    input wire logic [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] digital_vga_gain,
    input wire logic [DIGITAL_VARIABLE_GAIN_AMP_W-1:0] digital_vga_top,
    input wire logic [2:0]        front_amp_step,
    input wire logic [7:0]        front_amp_cap_db10,
    input wire logic [5:0]        amp_target_db
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_sync_enter: assert property (
        sync_detected && !rx_restart |=> loop_post_sync)
        else $error("post-sync state not entered");
    a_restart_exit: assert property (
        rx_restart |=> !loop_post_sync) else $error("restart kept post state");
    a_post_hold: assert property (
        loop_post_sync && !rx_restart |=> loop_post_sync)
        else $error("post state dropped without restart");
    a_pre_ki_even: assert property (
        !loop_post_sync |-> !integral_gain_half[0] && integral_gain_half != 0)
        else $error("pre-sync integral gain off table");
    a_pre_kp_even: assert property (
        !loop_post_sync |-> !proportional_gain_half[0]
            && proportional_gain_half != 0)
        else $error("pre-sync proportional gain off table");
    a_post_ki_half: assert property (
        loop_post_sync && integral_gain_half[0]
            |-> integral_gain_half == 4'h1)
        else $error("post-sync integral gain off table");
    a_rate_flag: assert property (
        rate_correction_en == (rate_offset_limit != 3'h0))
        else $error("rate enable disagrees with limit");
    a_target_table: assert property (
        amp_target_db inside {6'h18, 6'h1b, 6'h1e, 6'h21,
                              6'h24, 6'h26, 6'h28, 6'h2a})
        else $error("amplitude target off table");
    a_digital_variable_gain_amp_clamp: assert property (
        $past(arst_n) && $stable(digital_vga_top) |-> digital_vga_gain ==
        (($past(digital_variable_gain_amp_gain_req) > digital_vga_top) ? digital_vga_top
                                                   : $past(digital_variable_gain_amp_gain_req)))
        else $error("digital gain not clamped");
    a_front_floor: assert property (
        $past(arst_n) && $stable(front_amp_cap_db10)
            |-> front_amp_step >= $past(front_amp_step_req))
        else $error("front amp step below request");
endmodule // bsg_chk

bind bsg_bitsync_agc_cfg bsg_chk #(.DIGITAL_VARIABLE_GAIN_AMP_W(DIGITAL_VARIABLE_GAIN_AMP_W), .DIGITAL_VARIABLE_GAIN_AMP_TOP(DIGITAL_VARIABLE_GAIN_AMP_TOP))
    i_bsg_chk (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sync_detected(sync_detected),
    .rx_restart(rx_restart), .digital_variable_gain_amp_gain_req(digital_variable_gain_amp_gain_req),
    .front_amp_step_req(front_amp_step_req),
    .loop_post_sync(loop_post_sync), .integral_gain_half(integral_gain_half),
    .proportional_gain_half(proportional_gain_half),
    .rate_correction_en(rate_correction_en),
    .rate_offset_limit(rate_offset_limit),
    .digital_vga_gain(digital_vga_gain), .digital_vga_top(digital_vga_top),
    .front_amp_step(front_amp_step), .front_amp_cap_db10(front_amp_cap_db10),
    .amp_target_db(amp_target_db));
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench for the bit sync and gain limit block
`timescale 1ns/1ns
`default_nettype none
`include "bsg_defines.vh"
module tb;
    logic       mclk, arst_n, reg_wr, reg_rd, sync_detected, rx_restart;
    logic       loop_post_sync, rate_correction_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, front_amp_cap_db10, d;
    logic [3:0] integral_gain_half, proportional_gain_half;
    logic [2:0] digital_variable_gain_amp_gain_req, front_amp_step_req, rate_offset_limit;
    logic [2:0] digital_vga_gain, digital_vga_top, front_amp_step;
    logic [5:0] amp_target_db;
    int         bad_count, compares;
    logic [7:0] cap_t [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a,
                              8'h5c, 8'h73, 8'h92, 8'hab};
    logic [7:0] tgt_t [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21,
                              8'h24, 8'h26, 8'h28, 8'h2a};
    logic [7:0] lim_t [4] = '{8'h00, 8'h01, 8'h02, 8'h04};

    bsg_bitsync_agc_cfg i_bsg_bitsync_agc_cfg (.mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_detected(sync_detected), .rx_restart(rx_restart),
        .digital_variable_gain_amp_gain_req(digital_variable_gain_amp_gain_req), .front_amp_step_req(front_amp_step_req),
        .loop_post_sync(loop_post_sync),
        .integral_gain_half(integral_gain_half),
        .proportional_gain_half(proportional_gain_half),
        .rate_correction_en(rate_correction_en),
        .rate_offset_limit(rate_offset_limit),
        .digital_vga_gain(digital_vga_gain), .digital_vga_top(digital_vga_top),
        .front_amp_step(front_amp_step),
        .front_amp_cap_db10(front_amp_cap_db10),
        .amp_target_db(amp_target_db));

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task settle;
        @(posedge mclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        #1;
        chk(8'(integral_gain_half), 8'h04);
        chk(8'(proportional_gain_half), 8'h06);
        chk(8'(rate_correction_en), 8'h00);
        chk(8'(amp_target_db), 8'h21);
        chk(front_amp_cap_db10, 8'h00);
        chk(8'(digital_vga_top), 8'h07);
        rd(`BSG_ADDR_BIT_SYNC_CONFIG);
        chk(d, 8'h6c);
        rd(`BSG_ADDR_GAIN_CTRL_LIMITS);
        chk(d, 8'h03);
    endtask
    task t_regs;
        wr(8'h55, 8'hff);
        wr(`BSG_ADDR_LOOP_STATUS, 8'hff);
        rd(8'h55);
        chk(d, 8'h00);
        rd(`BSG_ADDR_LOOP_STATUS);
        chk(d, 8'h40);
        settle;
        chk(reg_rdata, 8'h00);
    endtask
    task t_rate;
        for (int i = 0; i < 4; i++) begin
            wr(`BSG_ADDR_BIT_SYNC_CONFIG, {6'h1b, 2'(i)});
            settle;
            chk(8'(rate_offset_limit), lim_t[i]);
            chk(8'(rate_correction_en), 8'(i != 0));
            rd(`BSG_ADDR_BIT_SYNC_CONFIG);
            chk(d, {6'h1b, 2'(i)});
        end
    endtask
    task t_agc;
        for (int i = 0; i < 8; i++) begin
            wr(`BSG_ADDR_GAIN_CTRL_LIMITS, {2'(i), 3'(i), 3'(i)});
            digital_variable_gain_amp_gain_req      <= 3'h7;
            front_amp_step_req <= 3'h0;
            settle;
            chk(front_amp_cap_db10, cap_t[i]);
            chk(8'(amp_target_db), tgt_t[i]);
            chk(8'(digital_vga_top), 8'(7 - (i % 4)));
            chk(8'(digital_vga_gain), 8'(7 - (i % 4)));
            chk(8'(front_amp_step), 8'(i));
            @(posedge mclk);
            digital_variable_gain_amp_gain_req      <= 3'h0;
            front_amp_step_req <= 3'h7;
            settle;
            chk(8'(digital_vga_gain), 8'h00);
            chk(8'(front_amp_step), 8'h07);
        end
    endtask
    task t_sync;
        logic [7:0] ki, kp;
        for (int i = 0; i < 16; i++) begin
            ki = 8'(2 * ((i >> 2) + 1));
            kp = 8'(2 * ((i & 3) + 1));
            wr(`BSG_ADDR_BIT_SYNC_CONFIG, {4'(i), 2'(i), 2'h0});
            settle;
            chk(8'(integral_gain_half), ki);
            chk(8'(proportional_gain_half), kp);
            @(posedge mclk);
            sync_detected <= 1'b1;
            @(posedge mclk);
            sync_detected <= 1'b0;
            #1;
            chk(8'(loop_post_sync), 8'h01);
            chk(8'(integral_gain_half), i[1] ? 8'h01 : ki);
            chk(8'(proportional_gain_half), i[0] ? 8'h02 : kp);
            rd(`BSG_ADDR_LOOP_STATUS);
            chk(d, {i[1] ? 4'h1 : ki[3:0], 4'h1});
            @(posedge mclk);
            rx_restart    <= 1'b1;
            sync_detected <= 1'b1;
            @(posedge mclk);
            rx_restart    <= 1'b0;
            sync_detected <= 1'b0;
            #1;
            chk(8'(loop_post_sync), 8'h00);
            chk(8'(integral_gain_half), ki);
        end
    endtask
    // Second reset mid-run, with a sync pending and limits changed
    task t_rst2;
        wr(`BSG_ADDR_GAIN_CTRL_LIMITS, 8'hc7);
        @(posedge mclk);
        sync_detected <= 1'b1;
        arst_n        <= 1'b0;
        repeat (2) @(posedge mclk);
        sync_detected <= 1'b0;
        arst_n        <= 1'b1;
        #1;
        chk(8'(loop_post_sync), 8'h00);
        chk(8'(integral_gain_half), 8'h04);
        chk(8'(amp_target_db), 8'h21);
        chk(8'(digital_vga_top), 8'h07);
        rd(`BSG_ADDR_BIT_SYNC_CONFIG);
        chk(d, 8'h6c);
        rd(`BSG_ADDR_GAIN_CTRL_LIMITS);
        chk(d, 8'h03);
        settle;
        chk(8'(front_amp_step), 8'h07);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sync_detected = 1'b0;
        rx_restart = 1'b0;
        digital_variable_gain_amp_gain_req = 3'h0;
        front_amp_step_req = 3'h0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset;
        t_regs;
        t_rate;
        t_agc;
        t_sync;
        t_rst2;
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
